/* design/npb_map.svh */
// register offsets, bit positions and bus constants of the parallel bus port
// assumes a 32-bit APB slave with a 12-bit byte address
`ifndef NPB_MAP_SVH
`define NPB_MAP_SVH
`define NPB_IDX_ELEMENT 5'h01
`define NPB_IDX_FINAL 5'h02
`define NPB_IDX_METRIC 5'h03
`define NPB_IDX_LABEL 5'h04
`define NPB_DATA_IDLE 16'hFFFF
`define NPB_UPDATE_EDGE 2'h3
`define NPB_OFS_NETSTAT 12'h000
`define NPB_OFS_RECSTAT 12'h004
`define NPB_OFS_CTRL 12'h008
`define NPB_OFS_CMD 12'h00C
`define NPB_OFS_RESULT 12'h010
`define NPB_BIT_AGREE 3
`define NPB_BIT_AMBIG 2
`define NPB_BIT_CHAIN_IN 0
`define NPB_BIT_CHAIN_OUT 1
`define NPB_BIT_BUSY 4
`define NPB_CTRL_BUS_OFF 0
`define NPB_CTRL_OVERRIDE 1
`define NPB_CMD_RW 24
`define NPB_SYNC_LAG 2'h2
`define NPB_PIN_IDLE 6'h38
`endif

/* design/npb_pkg.sv */
// types shared by the parallel bus port
// assumes npb_map.svh for all numeric constants
package npb_pkg;
   typedef struct packed {
      logic strobe;
      logic rw;
      logic [4:0] index;
      logic [15:0] data;
   } npb_bus_t;
   typedef enum logic [1:0] {
      M_IDLE,
      M_STROBE,
      M_WAIT
   } npb_mst_t;
endpackage : npb_pkg

/* design/npb_port.sv */
// parallel command bus port of a neuron chip, device side
// assumes data, ready and match pins are resolved as wired-AND outside; neuron core is on pclk
`timescale 1ns/10ps
`include "npb_map.svh"

module npb_port (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // parallel bus pins
   input wire npb_pkg::npb_bus_t bus_in,
   output npb_pkg::npb_bus_t bus_out,
   output npb_pkg::npb_bus_t bus_oe,
   input wire logic ready_in,
   output logic ready_out,
   output logic ready_oe,
   input wire logic agreed_match_n_in,
   output logic agreed_match_n_out,
   output logic agreed_match_n_oe,
   input wire logic ambiguous_match_n_in,
   output logic ambiguous_match_n_out,
   output logic ambiguous_match_n_oe,
   // chip straps and chain
   input wire logic single_chip,
   input wire logic chain_in,
   output logic chain_out,
   output logic bus_occupied,
   // neuron core side
   output npb_pkg::npb_bus_t core_cmd,
   output logic core_cmd_valid,
   output logic neurons_active,
   input wire logic core_busy,
   input wire logic [15:0] core_rdata,
   input wire logic core_agree,
   input wire logic core_ambig,
   input wire logic core_novelty,
   input wire logic core_last_committed,
   input wire logic reco_active,
   input wire logic reco_final,
   input wire logic label_valid_pulse,
   input wire logic [15:0] live_class_label
);
   npb_pkg::npb_bus_t bus_m;
   npb_pkg::npb_bus_t bus_s;
   logic [5:0] pin_m;
   logic [5:0] pin_s;
   npb_pkg::npb_mst_t mst;
   npb_pkg::npb_mst_t next_mst;
   logic [24:0] cmd_reg;
   logic [15:0] result;
   logic [1:0] ctrl;
   logic [1:0] own_dly;
   logic [1:0] upd_cnt;
   logic [1:0] wait_cnt;
   logic [15:0] data_val;
   logic read_pend;
   logic mix_cmd;
   logic agree_drv;
   logic ambig_drv;
   logic novelty_drv;
   logic rdy_low;
   logic chain_out_q;

   // two-flop synchronisers for every pin read from outside
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_m <= '0;
         bus_s <= '0;
         // idle pin levels, so no false agreement or low ready after reset
         pin_m <= `NPB_PIN_IDLE;
         pin_s <= `NPB_PIN_IDLE;
      end else begin
         bus_m <= bus_in;
         bus_s <= bus_m;
         pin_m <= {ready_in, agreed_match_n_in, ambiguous_match_n_in,
                   single_chip, chain_in, 1'b0};
         pin_s <= pin_m;
      end
   end

   wire ready_s = pin_s[5];
   wire agree_s = ~pin_s[4];
   wire ambig_s = ~pin_s[3];
   wire single_s = pin_s[2];
   wire chain_in_s = pin_s[1];
   wire bus_off = single_s | ctrl[`NPB_CTRL_BUS_OFF];
   wire occupied = (mst != npb_pkg::M_IDLE);

   // own commands reach the synced strobe two cycles after driving it
   wire own_seen = own_dly[1];
   // external strobes during own activity are dropped
   wire take = bus_s.strobe & ~bus_off & chain_in_s
               & (~occupied | own_seen);
   wire take_wr = take & ~bus_s.rw;
   wire take_rd = take & bus_s.rw;
   wire is_final = bus_s.index == `NPB_IDX_FINAL;
   wire is_elem = bus_s.index == `NPB_IDX_ELEMENT;
   wire is_label = bus_s.index == `NPB_IDX_LABEL;
   wire is_metric = bus_s.index == `NPB_IDX_METRIC;
   wire mix_now = (take_wr & (is_final | is_label))
                  | (take_rd & (is_metric | is_label));
   wire final_evt = (take_wr & is_final) | reco_final;
   wire elem_evt = take_wr & is_elem;
   wire override = ctrl[`NPB_CTRL_OVERRIDE] & reco_active;

   // command to the neuron core, one pulse per taken strobe cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_cmd <= '0;
         core_cmd_valid <= 1'b0;
      end else begin
         core_cmd <= bus_s;
         core_cmd_valid <= take;
      end
   end

   // ready is pulled low in the cycle after a taken strobe and while the core works
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdy_low <= 1'b0;
      end else begin
         rdy_low <= take | core_busy;
      end
   end

   // read data and wired mixing of neuron responses
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_val <= `NPB_DATA_IDLE;
         read_pend <= 1'b0;
         mix_cmd <= 1'b0;
      end else begin
         if (take) begin
            read_pend <= take_rd;
            mix_cmd <= mix_now;
            data_val <= `NPB_DATA_IDLE;
         end else if (override & label_valid_pulse) begin
            data_val <= live_class_label;
         end else if (mix_cmd & core_busy) begin
            data_val <= core_rdata;
         end else if (read_pend & ~bus_s.strobe & ~core_busy) begin
            data_val <= core_rdata;
            read_pend <= 1'b0;
            mix_cmd <= 1'b0;
         end else if (~read_pend & ~override) begin
            data_val <= `NPB_DATA_IDLE;
            mix_cmd <= 1'b0;
         end
      end
   end

   // agreement and ambiguity update on the third edge of a final write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         upd_cnt <= 2'h0;
         agree_drv <= 1'b0;
         ambig_drv <= 1'b0;
         novelty_drv <= 1'b0;
      end else begin
         if (final_evt) begin
            upd_cnt <= `NPB_UPDATE_EDGE;
         end else if (upd_cnt != 2'h0) begin
            upd_cnt <= upd_cnt - 2'h1;
         end
         if (upd_cnt == 2'h1) begin
            agree_drv <= core_agree;
            ambig_drv <= core_ambig;
         end else if (elem_evt) begin
            agree_drv <= 1'b0;
            ambig_drv <= 1'b0;
         end
         novelty_drv <= mix_cmd & ~read_pend & core_busy
                        & core_novelty;
      end
   end

   // chain-out latches high; forgetting neurons needs a reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chain_out_q <= 1'b0;
      end else if (chain_in_s & core_last_committed) begin
         chain_out_q <= 1'b1;
      end
   end

   // own master, driven from the command register
   wire cmd_wr = psel & penable & pwrite & (paddr == `NPB_OFS_CMD);
   always_comb begin
      next_mst = mst;
      case (mst)
         npb_pkg::M_IDLE: begin
            if (cmd_wr & ~bus_off & ready_s) begin
               next_mst = npb_pkg::M_STROBE;
            end
         end
         npb_pkg::M_STROBE: begin
            next_mst = npb_pkg::M_WAIT;
         end
         npb_pkg::M_WAIT: begin
            if (wait_cnt == 2'h0 & ready_s & ~read_pend) begin
               next_mst = npb_pkg::M_IDLE;
            end
         end
         default: begin
            next_mst = npb_pkg::M_IDLE;
         end
      endcase
   end

   // wait covers the sync lag so the old ready level is not trusted
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mst <= npb_pkg::M_IDLE;
         wait_cnt <= 2'h0;
         own_dly <= 2'h0;
         result <= `NPB_DATA_IDLE;
      end else begin
         mst <= next_mst;
         own_dly <= {own_dly[0], mst == npb_pkg::M_STROBE};
         if (mst == npb_pkg::M_STROBE) begin
            wait_cnt <= `NPB_SYNC_LAG + 2'h1;
         end else if (wait_cnt != 2'h0) begin
            wait_cnt <= wait_cnt - 2'h1;
         end
         if (mst == npb_pkg::M_WAIT & next_mst == npb_pkg::M_IDLE) begin
            result <= bus_s.data;
         end
      end
   end

   // apb registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= 2'h0;
         cmd_reg <= '0;
      end else if (psel & penable & pwrite) begin
         if (paddr == `NPB_OFS_CTRL) begin
            ctrl <= pwdata[1:0];
         end
         if (cmd_wr & ~occupied) begin
            cmd_reg <= pwdata[24:0];
         end
      end
   end

   wire [31:0] stat_word = {27'h0, occupied, agree_s, ambig_s,
                            chain_out_q, chain_in_s};
   wire hit_stat = (paddr == `NPB_OFS_NETSTAT)
                   | (paddr == `NPB_OFS_RECSTAT);
   wire hit_ctrl = paddr == `NPB_OFS_CTRL;
   wire hit_cmd = paddr == `NPB_OFS_CMD;
   wire hit_res = paddr == `NPB_OFS_RESULT;
   wire hit_any = hit_stat | hit_ctrl | hit_cmd | hit_res;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~hit_any;
   assign prdata = hit_stat ? stat_word :
                   hit_ctrl ? {30'h0, ctrl} :
                   hit_cmd ? {7'h0, cmd_reg} :
                   hit_res ? {16'h0, result} : 32'h0;

   // pin drive, strobe and command lines only from own master
   wire drv_cmd = (mst == npb_pkg::M_STROBE) & ~bus_off;
   assign bus_out.strobe = 1'b1;
   assign bus_out.rw = cmd_reg[`NPB_CMD_RW];
   assign bus_out.index = cmd_reg[20:16];
   assign bus_out.data = cmd_reg[15:0];
   // released one cycle after strobe so others can drive next edge
   assign bus_oe.strobe = drv_cmd;
   assign bus_oe.rw = drv_cmd;
   assign bus_oe.index = {5{drv_cmd}};
   // only zero bits of the command or read value are enabled; driven levels always come from cmd_reg
   assign bus_oe.data = bus_off ? 16'h0 :
                        drv_cmd ? ~cmd_reg[15:0] : ~data_val;
   assign ready_out = 1'b0;
   assign ready_oe = rdy_low;
   assign agreed_match_n_out = 1'b0;
   assign agreed_match_n_oe = agree_drv;
   assign ambiguous_match_n_out = 1'b0;
   // ambiguity is only ever pulled by this chip's neurons
   assign ambiguous_match_n_oe = ambig_drv | novelty_drv;
   assign chain_out = chain_out_q;
   assign bus_occupied = occupied;
   assign neurons_active = chain_in_s;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence final_taken_s;
      take_wr & is_final & ~reco_final;
   endsequence
   sequence third_edge_s;
      ##3 1'b1;
   endsequence

   ready_low_a: assert property (take |=> ready_oe)
      else $error("ready not pulled after command");
   agree_upd_a: assert property (final_taken_s
      ##1 (~take_wr & ~reco_final)[*2]
      |-> ##2 agreed_match_n_oe == $past(core_agree))
      else $error("agreement not updated on third edge");
   ambig_upd_a: assert property (final_taken_s
      ##1 (~take_wr & ~reco_final)[*2]
      |-> ##2 (novelty_drv
               | ambiguous_match_n_oe == $past(core_ambig)))
      else $error("ambiguity not updated on third edge");
   agree_rel_a: assert property (elem_evt & upd_cnt != 2'h1
      |=> ~agreed_match_n_oe)
      else $error("agreement not released at element write");
   stat_bits_a: assert property (stat_word[`NPB_BIT_AGREE]
      == ~$past(agreed_match_n_in, 2) && stat_word[`NPB_BIT_AMBIG]
      == ~$past(ambiguous_match_n_in, 2))
      else $error("status bits do not follow lines");
   chain_hold_a: assert property (chain_out |=> chain_out)
      else $error("chain out dropped");
   single_quiet_a: assert property (bus_off |-> bus_oe == '0)
      else $error("bus driven while disabled");
   own_strobe_a: assert property ($rose(bus_oe.strobe)
      |-> $past(ready_s))
      else $error("own strobe without ready");
   idle_chip_a: assert property (~chain_in_s |-> ~take)
      else $error("command taken while chain idle");
   label_drive_a: assert property (override & label_valid_pulse
      & ~take |=> data_val == $past(live_class_label))
      else $error("live label not driven");
endmodule : npb_port

/* tb/npb_master.sv */
// external master model on the shared parallel bus
// assumes the bench resolves the pins; oe high while this model drives
`timescale 1ns/10ps
module npb_master (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // request from the bench
   input wire logic go,
   input wire npb_pkg::npb_bus_t req,
   output logic done,
   output logic [15:0] rdata,
   // resolved pins
   input wire logic ready_lvl,
   input wire logic occupied,
   input wire logic [15:0] data_lvl,
   output npb_pkg::npb_bus_t drv,
   output logic drv_oe
);
   wire logic clear = ready_lvl & ~occupied & presetn;
   initial begin
      drv = '0;
      drv_oe = 1'b0;
      done = 1'b1;
      rdata = 16'hFFFF;
   end
   always begin
      @(posedge go);
      done = 1'b0;
      @(negedge pclk);
      while (!clear) @(negedge pclk);
      drv = req;
      drv_oe = 1'b1;
      @(negedge pclk);
      drv_oe = 1'b0;
      // a refused command never pulls ready, so the wait for it is bounded
      // levels are read at falling edges, after rising-edge updates settle
      repeat (8) begin
         @(negedge pclk);
         if (!ready_lvl) break;
      end
      while (!ready_lvl) @(negedge pclk);
      rdata = data_lvl;
      done = 1'b1;
   end
endmodule : npb_master

/* tb/neuron_parallel_bus_port_bench.sv */
// self-checking bench of the parallel bus port
// assumes npb_master on the pins; data, ready and match lines resolve with pull-ups
`timescale 1ns/10ps
`include "npb_map.svh"
module neuron_parallel_bus_port_bench;
   typedef struct {
      logic [11:0] a;
      logic [31:0] d;
      logic e;
   } npb_row_t;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, go;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic done, p_oe, single_chip, chain_in, chain_out, bus_occupied;
   logic rdy_oe, agr_oe, amb_oe, cmd_v, act, busy, agree, ambig, novel;
   logic last_c, reco, lvp, rfin;
   logic [15:0] core_rdata, live, rdata;
   npb_pkg::npb_bus_t bo, bv, lvl, req, pdrv, ccmd, last_cmd, pin_cmd;
   int err_total, n_tests, n_cmd, cyc;
   npb_row_t rows [5] = '{'{12'h000, 32'h1, 1'b0}, '{12'h004, 32'h1, 1'b0},
      '{12'h008, 32'h0, 1'b0}, '{12'h010, 32'hFFFF, 1'b0},
      '{12'h014, 32'h0, 1'b1}};
   // released strobe, direction and index lines fall to a pull-down
   assign lvl.strobe = bo.strobe ? bv.strobe : p_oe & pdrv.strobe;
   assign lvl.rw = bo.rw ? bv.rw : p_oe & pdrv.rw;
   assign lvl.index = p_oe ? pdrv.index : bo.index & bv.index;
   assign lvl.data = ~(bo.data
      | {16{p_oe & ~pdrv.rw}} & ~pdrv.data);
   wire logic rdy = ~rdy_oe;
   wire logic agr = ~agr_oe;
   wire logic amb = ~amb_oe;
   npb_port dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .bus_in(lvl), .bus_out(bv),
      .bus_oe(bo), .ready_in(rdy), .ready_out(), .ready_oe(rdy_oe),
      .agreed_match_n_in(agr), .agreed_match_n_out(),
      .agreed_match_n_oe(agr_oe), .ambiguous_match_n_in(amb),
      .ambiguous_match_n_out(), .ambiguous_match_n_oe(amb_oe),
      .single_chip(single_chip), .chain_in(chain_in), .chain_out(chain_out),
      .bus_occupied(bus_occupied), .core_cmd(ccmd), .core_cmd_valid(cmd_v),
      .neurons_active(act), .core_busy(busy), .core_rdata(core_rdata),
      .core_agree(agree), .core_ambig(ambig), .core_novelty(novel),
      .core_last_committed(last_c), .reco_active(reco), .reco_final(rfin),
      .label_valid_pulse(lvp), .live_class_label(live));
   npb_master ext_m (.pclk(pclk), .presetn(presetn), .go(go), .req(req),
      .done(done), .rdata(rdata), .ready_lvl(rdy), .occupied(bus_occupied),
      .data_lvl(lvl.data), .drv(pdrv), .drv_oe(p_oe));
   task automatic conclude();
      $display("errors %0d checks %0d", err_total, n_tests);
      if (err_total == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic start(input logic w, input logic [4:0] x,
      input logic [15:0] d);
      @(posedge pclk);
      req <= '{1'b1, w, x, d};
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
   endtask : start
   task automatic ext(input logic w, input logic [4:0] x,
      input logic [15:0] d);
      start(w, x, d);
      @(posedge pclk);
      while (done !== 1'b1) @(posedge pclk);
      repeat (4) @(posedge pclk);
   endtask : ext
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cmd_v === 1'b1) begin
         n_cmd <= n_cmd + 1;
         last_cmd <= ccmd;
      end
      if (bo.strobe === 1'b1) pin_cmd <= lvl;
      if (cyc == 6000) begin
         err_total++;
         conclude();
      end
   end
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   initial begin
      {presetn, psel, penable, pwrite, go, single_chip, chain_in} = '0;
      {busy, agree, ambig, novel, last_c, reco, lvp, rfin} = '0;
      {paddr, pwdata, core_rdata, live, req} = '0;
      {err_total, n_tests, n_cmd, cyc} = '0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      chk({chain_out, bus_occupied, rdy_oe, agr_oe, amb_oe}, 0);
      ext(1'b0, `NPB_IDX_ELEMENT, 16'h0001);
      chk({act, n_cmd[30:0]}, 0);
      chain_in <= 1'b1;
      repeat (3) @(posedge pclk);
      chk(act, 1);
      foreach (rows[i]) begin
         apb(1'b0, rows[i].a, 0);
         chk(r, rows[i].d);
         chk(e, rows[i].e);
      end
      ext(1'b0, `NPB_IDX_ELEMENT, 16'hA5C3);
      chk({last_cmd.rw, last_cmd.index, last_cmd.data}, 22'h01A5C3);
      core_rdata <= 16'h1234;
      ext(1'b1, `NPB_IDX_METRIC, 16'hFFFF);
      chk(rdata, 16'h1234);
      chk({last_cmd.rw, last_cmd.index, n_cmd[7:0]}, 14'h2302);
      for (int k = 0; k < 2; k++) begin
         agree <= (k == 0);
         ambig <= (k == 1);
         ext(1'b0, `NPB_IDX_FINAL, 16'h0000);
         chk({agr, amb}, k ? 2'b10 : 2'b01);
         apb(1'b0, k ? `NPB_OFS_RECSTAT : `NPB_OFS_NETSTAT, 0);
         chk(r[3:2], k ? 2'b01 : 2'b10);
         ext(1'b0, `NPB_IDX_ELEMENT, 16'h0000);
         chk({agr, amb}, 2'b11);
      end
      agree <= 1'b0;
      ambig <= 1'b1;
      rfin <= 1'b1;
      @(posedge pclk);
      rfin <= 1'b0;
      repeat (5) @(posedge pclk);
      chk({agr, amb}, 2'b10);
      ext(1'b0, `NPB_IDX_ELEMENT, 16'h0000);
      chk({agr, amb}, 2'b11);
      start(1'b0, `NPB_IDX_LABEL, 16'h0007);
      // busy only after the strobe is out, else ready would hold it back
      @(posedge pclk);
      busy <= 1'b1;
      novel <= 1'b1;
      repeat (5) @(posedge pclk);
      chk({rdy, amb}, 0);
      busy <= 1'b0;
      novel <= 1'b0;
      while (done !== 1'b1) @(posedge pclk);
      single_chip <= 1'b1;
      ext(1'b0, `NPB_IDX_ELEMENT, 16'h0002);
      chk(n_cmd, 8);
      single_chip <= 1'b0;
      last_c <= 1'b1;
      @(posedge pclk);
      last_c <= 1'b0;
      repeat (3) @(posedge pclk);
      chk(chain_out, 1);
      apb(1'b1, `NPB_OFS_CMD, 32'h00013C3C);
      repeat (2) @(posedge pclk);
      chk(bus_occupied, 1);
      while (bus_occupied === 1'b1) @(posedge pclk);
      chk({pin_cmd.strobe, pin_cmd.rw, pin_cmd.index, pin_cmd.data},
         23'h413C3C);
      apb(1'b1, `NPB_OFS_CTRL, 32'h2);
      reco <= 1'b1;
      live <= 16'h0F5A;
      lvp <= 1'b1;
      @(posedge pclk);
      lvp <= 1'b0;
      repeat (3) @(posedge pclk);
      chk(lvl.data, 16'h0F5A);
      conclude();
   end
endmodule : neuron_parallel_bus_port_bench
